// ---- hw/fsbl_ctrl.sv ----
/*
  flash command controller: suspend/resume, blank check and block lock,
  reached over apb. a write to the command data register is one flash bus
  write cycle at the address held in the command address register; a read
  of the read register is one flash read at that address.
  assumes wp_n and ce_n arrive asynchronously from pins.
*/
// Chosen here: the placing of the registers and the APB interface to the registers.
// Notes on behaviour
// - suspend code at any address, read modes kept
// - halt after latency, suspend bits set in the same cycle
// - protect change while suspended aborts, flags error
// - otp programming ignores suspend
// - program into erase-suspended block flags program error
// - program under erase suspend, itself suspendable
// - while suspended only reads, clear, resume; program and lock under erase suspend
// - erase refused during program suspend
// - hardware reset aborts suspended work
// - chip disable gives standby once idle, context kept
// - resume continues op, clears suspend bit
// - nested resume continues program before erase
// - one block blank check, refused when suspended
// - blank check setup/confirm, partition to status
// - ready bit low while checking, high after
// - non-blank block flags bit five, erase error
// - during blank check only status reads, no suspend
// - reset locks all blocks, locked refuse program/erase
// - lock setup then confirm selects lock/unlock
// - identifier mode offset two returns lock state
// - lock refused while busy or program suspended
// - protect low holds and restores locked-down blocks
// - lock-down confirm marks block, cleared by reset
// - data bit zero locked, bit one down
module fsbl_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wp_n,
  input wire logic ce_n,
  output logic standby
);
  // local one-hot tracker for the first cycle of a two-cycle command
  typedef enum logic [5:0] {
    PD_NONE = 6'b000001,
    PD_ERASE = 6'b000010,
    PD_PROG = 6'b000100,
    PD_OTP = 6'b001000,
    PD_BLANK = 6'b010000,
    PD_LOCK = 6'b100000
  } fsbl_pend_e;

  // counter loads, cut to the counter width on purpose
  localparam logic [fsbl_pkg::CNT_W-1:0] ERS_LOAD = fsbl_pkg::ERS_CYC[fsbl_pkg::CNT_W-1:0];
  localparam logic [fsbl_pkg::CNT_W-1:0] PGM_LOAD = fsbl_pkg::PGM_CYC[fsbl_pkg::CNT_W-1:0];
  localparam logic [fsbl_pkg::CNT_W-1:0] BLANK_LOAD = fsbl_pkg::BLANK_CYC[fsbl_pkg::CNT_W-1:0];
  localparam logic [fsbl_pkg::CNT_W-1:0] SUSP_LOAD = fsbl_pkg::SUSP_CYC[fsbl_pkg::CNT_W-1:0];

  // apb response flops
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  // flash bus address latched by software
  logic [fsbl_pkg::ADDR_W-1:0] addr_q;
  // pin side, after two flops
  logic wp_low_s; // protect pin is low
  logic ce_n_s; // chip enable, still active low
  logic wp_low_q; // last protect level, for edges
  logic wp_assert; // protect went low
  logic wp_chg; // protect moved either way
  logic standby_q;
  // sequencer
  fsbl_pkg::fsbl_st_e st_q;
  fsbl_pend_e pend_q;
  logic esus_q; // erase suspended
  logic psus_q; // program suspended
  logic susp_pend_q; // suspend asked, latency running
  logic [fsbl_pkg::CNT_W-1:0] susp_cnt_q;
  logic [fsbl_pkg::CNT_W-1:0] ers_cnt_q; // erase context, kept over suspend
  logic [fsbl_pkg::CNT_W-1:0] pgm_cnt_q; // program, otp or blank check
  logic [fsbl_pkg::BLK_W-1:0] ers_blk_q;
  logic [fsbl_pkg::BLK_W-1:0] pgm_blk_q;
  logic pgm_mark_q; // running program leaves a non-erased word
  logic [fsbl_pkg::N_BLK-1:0] dirty_q; // block holds a programmed word
  logic perr_q;
  logic eerr_q;
  logic lerr_q;
  fsbl_pkg::fsbl_rmode_e rm_q [fsbl_pkg::N_PART];
  // lock bank view
  logic [fsbl_pkg::N_BLK-1:0] locked;
  logic [fsbl_pkg::N_BLK-1:0] lockdn;
  // decoded fields and strobes
  logic setup;
  logic access;
  logic wr_stb;
  logic [15:0] code;
  logic [fsbl_pkg::BLK_W-1:0] blk;
  logic [fsbl_pkg::PART_W-1:0] part;
  logic [7:0] ofs;
  logic idle;
  logic ers_done;
  logic pgm_done;
  logic susp_hit;
  logic blank_fail;
  logic [7:0] status_word;
  logic [15:0] rd_word;
  // command decode results
  fsbl_pend_e pend_d;
  logic pend_we;
  logic go_erase;
  logic go_prog;
  logic go_otp;
  logic go_blank;
  logic go_susp;
  logic go_res_p;
  logic go_res_e;
  logic lk_valid;
  logic [1:0] lk_code;
  logic rm_we;
  fsbl_pkg::fsbl_rmode_e rm_val;
  logic clr_err;
  logic perr_c;
  logic eerr_c;
  logic lerr_c;

  // true for the four offsets of the register view
  function automatic logic reg_known(input logic [7:0] a);
    return (a == fsbl_pkg::REG_CMD_ADDR) || (a == fsbl_pkg::REG_CMD_DATA) ||
      (a == fsbl_pkg::REG_READ) || (a == fsbl_pkg::REG_STATUS);
  endfunction

  // read mode commands, legal in every state but blank check
  function automatic logic is_read(input logic [15:0] c);
    return (c == fsbl_pkg::CMD_READ_ARRAY) || (c == fsbl_pkg::CMD_READ_STATUS) ||
      (c == fsbl_pkg::CMD_READ_ID) || (c == fsbl_pkg::CMD_READ_CFI);
  endfunction

  // read mode selected by a read command
  function automatic fsbl_pkg::fsbl_rmode_e rm_of(input logic [15:0] c);
    case (c)
      fsbl_pkg::CMD_READ_STATUS: return fsbl_pkg::RM_STATUS;
      fsbl_pkg::CMD_READ_ID: return fsbl_pkg::RM_ID;
      fsbl_pkg::CMD_READ_CFI: return fsbl_pkg::RM_CFI;
      default: return fsbl_pkg::RM_ARRAY;
    endcase
  endfunction

  // protect is inverted before the flops so reset matches its idle high level
  fsbl_sync #(
    .WIDTH(2)
  ) u_fsbl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .din({~wp_n, ce_n}),
    .dout({wp_low_s, ce_n_s})
  );

  fsbl_lock_bank u_fsbl_lock_bank (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .op_valid(lk_valid),
    .op_code(lk_code),
    .op_blk(blk),
    .wp_low(wp_low_s),
    .wp_assert(wp_assert),
    .locked(locked),
    .lockdn(lockdn)
  );

  assign setup = pclken && psel && !penable;
  assign access = pclken && psel && penable && pready_q;
  assign wr_stb = access && pwrite && (paddr == fsbl_pkg::REG_CMD_DATA);
  assign code = pwdata[15:0];
  assign blk = addr_q[fsbl_pkg::ADDR_BLK_LSB +: fsbl_pkg::BLK_W];
  assign part = addr_q[fsbl_pkg::ADDR_PART_LSB +: fsbl_pkg::PART_W];
  assign ofs = addr_q[fsbl_pkg::ADDR_OFS_LSB +: 8];
  assign idle = (st_q == fsbl_pkg::ST_IDLE);
  assign wp_assert = wp_low_s && !wp_low_q;
  assign wp_chg = wp_low_s != wp_low_q;
  assign ers_done = (st_q == fsbl_pkg::ST_ERASE) && (ers_cnt_q == fsbl_pkg::CNT_ONE);
  assign pgm_done = (st_q != fsbl_pkg::ST_IDLE) && (st_q != fsbl_pkg::ST_ERASE) &&
    (pgm_cnt_q == fsbl_pkg::CNT_ONE);
  assign susp_hit = susp_pend_q && (susp_cnt_q == fsbl_pkg::CNT_ONE) && !ers_done && !pgm_done;
  assign blank_fail = pgm_done && (st_q == fsbl_pkg::ST_BLANK) && dirty_q[pgm_blk_q];

  // status word, ready only once the halt has really happened
  always_comb begin
    status_word = 8'h00;
    status_word[fsbl_pkg::SR_READY] = idle;
    status_word[fsbl_pkg::SR_ESUS] = esus_q;
    status_word[fsbl_pkg::SR_EERR] = eerr_q;
    status_word[fsbl_pkg::SR_PERR] = perr_q;
    status_word[fsbl_pkg::SR_PSUS] = psus_q;
    status_word[fsbl_pkg::SR_LERR] = lerr_q;
  end

  // one flash read at the latched address, by the partition's mode
  always_comb begin
    rd_word = 16'h0000;
    case (rm_q[part])
      fsbl_pkg::RM_STATUS: rd_word = {8'h00, status_word};
      fsbl_pkg::RM_ID: begin
        if (ofs == fsbl_pkg::LOCK_WORD_OFS) begin
          rd_word = {14'h0000, lockdn[blk], locked[blk]};
        end
      end
      // no word store: a block reads erased until something is programmed
      fsbl_pkg::RM_ARRAY: rd_word = dirty_q[blk] ? 16'h0000 : fsbl_pkg::ERASED_WORD;
      default: rd_word = 16'h0000;
    endcase
  end

  // command decode, one flash write per strobe
  always_comb begin
    pend_d = PD_NONE;
    pend_we = 1'b0;
    go_erase = 1'b0;
    go_prog = 1'b0;
    go_otp = 1'b0;
    go_blank = 1'b0;
    go_susp = 1'b0;
    go_res_p = 1'b0;
    go_res_e = 1'b0;
    lk_valid = 1'b0;
    lk_code = fsbl_pkg::LK_LOCK;
    rm_we = 1'b0;
    rm_val = fsbl_pkg::RM_ARRAY;
    clr_err = 1'b0;
    perr_c = 1'b0;
    eerr_c = 1'b0;
    lerr_c = 1'b0;
    if (wr_stb) begin
      if (pend_q != PD_NONE) begin
        // second cycle: confirm or data
        pend_we = 1'b1;
        case (pend_q)
          PD_ERASE: begin
            if (code != fsbl_pkg::CMD_CONFIRM) begin
              eerr_c = 1'b1;
              perr_c = 1'b1;
            end else if (locked[blk]) begin
              eerr_c = 1'b1;
              lerr_c = 1'b1;
            end else begin
              go_erase = 1'b1;
            end
          end
          PD_PROG: begin
            if (esus_q && (blk == ers_blk_q)) begin
              perr_c = 1'b1;
            end else if (locked[blk]) begin
              perr_c = 1'b1;
              lerr_c = 1'b1;
            end else begin
              go_prog = 1'b1;
            end
          end
          PD_OTP: go_otp = 1'b1;
          PD_BLANK: begin
            if (code == fsbl_pkg::CMD_CONFIRM) begin
              go_blank = 1'b1;
            end else begin
              eerr_c = 1'b1;
              perr_c = 1'b1;
            end
          end
          PD_LOCK: begin
            lk_valid = 1'b1;
            case (code)
              fsbl_pkg::CMD_LOCK: lk_code = fsbl_pkg::LK_LOCK;
              fsbl_pkg::CMD_UNLOCK: lk_code = fsbl_pkg::LK_UNLOCK;
              fsbl_pkg::CMD_LOCKDOWN: lk_code = fsbl_pkg::LK_LDOWN;
              default: begin
                lk_valid = 1'b0; // bad confirm is a sequence error
                eerr_c = 1'b1;
                perr_c = 1'b1;
              end
            endcase
          end
          default: ;
        endcase
      end else if (st_q == fsbl_pkg::ST_BLANK) begin
        // only status reads while checking, suspend ignored
        if (code == fsbl_pkg::CMD_READ_STATUS) begin
          rm_we = 1'b1;
          rm_val = fsbl_pkg::RM_STATUS;
        end
      end else if (!idle) begin
        // running: reads and suspend only
        if (is_read(code)) begin
          rm_we = 1'b1;
          rm_val = rm_of(code);
        end else if (code == fsbl_pkg::CMD_SUSPEND && !susp_pend_q &&
          (st_q == fsbl_pkg::ST_ERASE || st_q == fsbl_pkg::ST_PROG)) begin
          go_susp = 1'b1; // otp never suspends
        end
      end else begin
        // idle, maybe with suspended work
        if (is_read(code)) begin
          rm_we = 1'b1;
          rm_val = rm_of(code);
        end else begin
          case (code)
            fsbl_pkg::CMD_CLR_STATUS: clr_err = 1'b1;
            fsbl_pkg::CMD_RESUME: begin
              // program first when both are parked
              if (psus_q && !wp_chg) begin
                go_res_p = 1'b1;
              end else if (esus_q && !wp_chg) begin
                go_res_e = 1'b1;
              end
            end
            fsbl_pkg::CMD_ERASE_SETUP: begin
              if (!esus_q && !psus_q) begin
                pend_d = PD_ERASE;
              end
            end
            fsbl_pkg::CMD_PGM_SETUP: begin
              if (!psus_q) begin
                pend_d = PD_PROG;
              end
            end
            fsbl_pkg::CMD_OTP_SETUP: begin
              if (!esus_q && !psus_q) begin
                pend_d = PD_OTP;
              end
            end
            fsbl_pkg::CMD_BLANK_SETUP: begin
              if (!esus_q && !psus_q) begin
                pend_d = PD_BLANK;
              end
            end
            fsbl_pkg::CMD_LOCK_SETUP: begin
              if (!psus_q) begin
                pend_d = PD_LOCK;
              end
            end
            default: ;
          endcase
          if (pend_d != PD_NONE) begin
            pend_we = 1'b1;
            rm_we = 1'b1;
            rm_val = fsbl_pkg::RM_STATUS;
          end
        end
      end
    end
  end

  // apb answers one cycle after setup, data stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (pclken) begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !reg_known(paddr);
      if (setup && !pwrite) begin
        case (paddr)
          fsbl_pkg::REG_CMD_ADDR: prdata_q <= {19'h00000, addr_q};
          fsbl_pkg::REG_READ: prdata_q <= {16'h0000, rd_word};
          fsbl_pkg::REG_STATUS: prdata_q <= {24'h000000, status_word};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // flash address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
    end else if (access && pwrite && paddr == fsbl_pkg::REG_CMD_ADDR) begin
      addr_q <= pwdata[fsbl_pkg::ADDR_W-1:0];
    end
  end

  // pending first cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= PD_NONE;
    end else if (pclken && pend_we) begin
      pend_q <= pend_d;
    end
  end

  // sequencer; reset drops any suspended work
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fsbl_pkg::ST_IDLE;
      esus_q <= 1'b0;
      psus_q <= 1'b0;
      susp_pend_q <= 1'b0;
      susp_cnt_q <= '0;
      ers_cnt_q <= '0;
      pgm_cnt_q <= '0;
      ers_blk_q <= '0;
      pgm_blk_q <= '0;
      pgm_mark_q <= 1'b0;
    end else if (pclken) begin
      if (go_erase) begin
        st_q <= fsbl_pkg::ST_ERASE;
        ers_cnt_q <= ERS_LOAD;
        ers_blk_q <= blk;
      end else if (go_prog) begin
        st_q <= fsbl_pkg::ST_PROG;
        pgm_cnt_q <= PGM_LOAD;
        pgm_blk_q <= blk;
        pgm_mark_q <= code != fsbl_pkg::ERASED_WORD;
      end else if (go_otp) begin
        st_q <= fsbl_pkg::ST_OTP;
        pgm_cnt_q <= PGM_LOAD;
        pgm_mark_q <= 1'b0;
      end else if (go_blank) begin
        st_q <= fsbl_pkg::ST_BLANK;
        pgm_cnt_q <= BLANK_LOAD;
        pgm_blk_q <= blk;
      end else if (go_res_p) begin
        st_q <= fsbl_pkg::ST_PROG; // counter kept, so it goes on
        psus_q <= 1'b0;
      end else if (go_res_e) begin
        st_q <= fsbl_pkg::ST_ERASE;
        esus_q <= 1'b0;
      end else if (ers_done || pgm_done) begin
        st_q <= fsbl_pkg::ST_IDLE; // finishing beats a late suspend
        susp_pend_q <= 1'b0;
      end else if (susp_hit) begin
        st_q <= fsbl_pkg::ST_IDLE;
        susp_pend_q <= 1'b0;
        if (st_q == fsbl_pkg::ST_ERASE) begin
          esus_q <= 1'b1;
        end else begin
          psus_q <= 1'b1;
        end
      end else begin
        if (st_q == fsbl_pkg::ST_ERASE) begin
          ers_cnt_q <= ers_cnt_q - fsbl_pkg::CNT_ONE;
        end else if (!idle) begin
          pgm_cnt_q <= pgm_cnt_q - fsbl_pkg::CNT_ONE;
        end
        if (go_susp) begin
          susp_pend_q <= 1'b1; // work runs on through the latency
          susp_cnt_q <= SUSP_LOAD;
        end else if (susp_pend_q) begin
          susp_cnt_q <= susp_cnt_q - fsbl_pkg::CNT_ONE;
        end
      end
      // protect moved while parked: abandon the parked work
      if (wp_chg && (esus_q || psus_q)) begin
        esus_q <= 1'b0;
        psus_q <= 1'b0;
      end
    end
  end

  // blank tracking per block; reset assumes an erased array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dirty_q <= '0;
    end else if (pclken) begin
      if (ers_done) begin
        dirty_q[ers_blk_q] <= 1'b0;
      end
      if (pgm_done && st_q == fsbl_pkg::ST_PROG && pgm_mark_q) begin
        dirty_q[pgm_blk_q] <= 1'b1;
      end
    end
  end

  // error flags: a set in the clear's cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
      lerr_q <= 1'b0;
    end else if (pclken) begin
      perr_q <= (perr_q && !clr_err) || perr_c || (wp_chg && psus_q);
      eerr_q <= (eerr_q && !clr_err) || eerr_c || (wp_chg && esus_q) || blank_fail;
      lerr_q <= (lerr_q && !clr_err) || lerr_c;
    end
  end

  // read mode per partition; suspend and resume never touch it
  for (genvar p = 0; p < fsbl_pkg::N_PART; p++) begin : g_part
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rm_q[p] <= fsbl_pkg::RM_ARRAY;
      end else if (pclken && rm_we && part == p[fsbl_pkg::PART_W-1:0]) begin
        rm_q[p] <= rm_val;
      end
    end
  end

  // protect edge and standby; a deselected busy array stays active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_low_q <= 1'b0;
      standby_q <= 1'b0;
    end else if (pclken) begin
      wp_low_q <= wp_low_s;
      standby_q <= ce_n_s && idle; // context untouched
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign standby = standby_q;
endmodule

// ---- hw/fsbl_pkg.sv ----
/*
  shared constants for the flash suspend / blank check / lock controller:
  register map, command codes, status bit positions, timing.
  assumes a 10 MHz pclk and the apb register view described in the note.
*/
package fsbl_pkg;
  // array geometry
  localparam int N_BLK = 8;
  localparam int BLK_W = 3;
  localparam int N_PART = 4;
  localparam int PART_W = 2;
  localparam int CNT_W = 12;

  // apb byte offsets
  localparam logic [7:0] REG_CMD_ADDR = 8'h00;
  localparam logic [7:0] REG_CMD_DATA = 8'h04;
  localparam logic [7:0] REG_READ = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // fields of the command address register
  localparam int ADDR_OFS_LSB = 0;
  localparam int ADDR_BLK_LSB = 8;
  localparam int ADDR_PART_LSB = 11;
  localparam int ADDR_W = 13;
  localparam int STBY_BIT = 8;

  // command codes on the flash data bus
  localparam logic [15:0] CMD_NONE = 16'h0000;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h00d0;
  localparam logic [15:0] CMD_CONFIRM = 16'h00d0;
  localparam logic [15:0] CMD_BLANK_SETUP = 16'h00bc;
  localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] CMD_LOCK = 16'h0001;
  localparam logic [15:0] CMD_UNLOCK = 16'h00d0;
  localparam logic [15:0] CMD_LOCKDOWN = 16'h002f;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
  localparam logic [15:0] CMD_PGM_SETUP = 16'h0040;
  localparam logic [15:0] CMD_OTP_SETUP = 16'h00c0;
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [15:0] CMD_READ_ID = 16'h0090;
  localparam logic [15:0] CMD_READ_CFI = 16'h0098;
  localparam logic [15:0] CMD_CLR_STATUS = 16'h0050;

  // lock bank operations
  localparam logic [1:0] LK_LOCK = 2'h1;
  localparam logic [1:0] LK_UNLOCK = 2'h2;
  localparam logic [1:0] LK_LDOWN = 2'h3;

  // status word bit positions
  localparam int SR_READY = 7;
  localparam int SR_ESUS = 6;
  localparam int SR_EERR = 5;
  localparam int SR_PERR = 4;
  localparam int SR_PSUS = 2;
  localparam int SR_LERR = 1;

  localparam logic [7:0] LOCK_WORD_OFS = 8'h02;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // timing, times in ns and derived cycle counts
  localparam int CLK_PERIOD_NS = 100;
  localparam int SUSP_LAT_NS = 1000;
  localparam int PGM_TIME_NS = 2000;
  localparam int ERS_TIME_NS = 50000;
  localparam int BLANK_TIME_NS = 10000;
  localparam int SUSP_CYC = SUSP_LAT_NS / CLK_PERIOD_NS;
  localparam int PGM_CYC = (PGM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERS_CYC = (ERS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ERASE = 5'b00010,
    ST_PROG = 5'b00100,
    ST_OTP = 5'b01000,
    ST_BLANK = 5'b10000
  } fsbl_st_e;

  // per-partition read mode
  typedef enum logic [1:0] {
    RM_ARRAY = 2'h0,
    RM_STATUS = 2'h1,
    RM_ID = 2'h2,
    RM_CFI = 2'h3
  } fsbl_rmode_e;
endpackage

// ---- hw/fsbl_sync.sv ----
/*
  two-flop synchroniser for asynchronous pins.
  assumes the consumer reads only dout; stage one feeds stage two alone.
*/
module fsbl_sync #(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q; // first stage, read by dout only

  // two stages, frozen with the clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      dout <= '0;
    end else if (pclken) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ---- hw/fsbl_lock_bank.sv ----
/*
  per-block lock and lock-down bits with write-protect interaction.
  assumes wp_low is already synchronised and wp_assert is its rising edge.
*/
module fsbl_lock_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic op_valid,
  input wire logic [1:0] op_code,
  input wire logic [fsbl_pkg::BLK_W-1:0] op_blk,
  input wire logic wp_low,
  input wire logic wp_assert,
  output logic [fsbl_pkg::N_BLK-1:0] locked,
  output logic [fsbl_pkg::N_BLK-1:0] lockdn
);
  // one slice per block
  for (genvar b = 0; b < fsbl_pkg::N_BLK; b++) begin : g_blk
    logic hit;
    assign hit = op_valid && (op_blk == b[fsbl_pkg::BLK_W-1:0]);

    // reset leaves every block locked, none locked down
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        locked[b] <= 1'b1;
        lockdn[b] <= 1'b0;
      end else if (pclken) begin
        if (wp_assert && lockdn[b]) begin
          locked[b] <= 1'b1; // relock on protect assert
        end else if (hit) begin
          case (op_code)
            fsbl_pkg::LK_LOCK: locked[b] <= 1'b1;
            fsbl_pkg::LK_UNLOCK: begin
              // locked-down blocks hold while protected
              if (!(lockdn[b] && wp_low)) begin
                locked[b] <= 1'b0;
              end
            end
            fsbl_pkg::LK_LDOWN: begin
              lockdn[b] <= 1'b1; // lock-down alone does not lock
              if (wp_low) begin
                locked[b] <= 1'b1; // already protected: lock now
              end
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule

// ---- verif/fsbl_ctrl_props.sv ----
/* checker on the fsbl_ctrl ports.
   assumes status word reads come back on prdata at offset 0c. */
module fsbl_ctrl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic ce_n,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed status word read
  wire logic st_rd = psel && penable && pready && !pwrite && paddr == fsbl_pkg::REG_STATUS;
  a_esus_ready: assert property (st_rd && prdata[6] |-> prdata[7]) else $error("erase suspend while busy");
  a_psus_ready: assert property (st_rd && prdata[2] |-> prdata[7]) else $error("program suspend while busy");
  a_select_awake: assert property (!ce_n [*4] |-> !standby) else $error("standby while selected");
  a_answer_bound: assert property (psel && !penable |=> ##[0:15] pready) else $error("no bus answer");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
endmodule

// ---- verif/fsbl_host.sv ----
/* host model: apb master plus protect and select pins.
   assumes the bench top provides timeout(). */
module fsbl_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0,
  output logic wp_n = 1'b1,
  output logic ce_n = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one transfer; held until pready is seen at an edge, idle edge before it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 64);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!pready) fsbl_ctrl_tb.timeout();
  endtask
endmodule

// ---- verif/fsbl_ctrl_tb.sv ----
/* bench for fsbl_ctrl: lock, blank check, suspend and resume.
   assumes commands go through the address and data registers. */
module fsbl_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, wp_n, ce_n, standby;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int miscompares = 0;
  int comparisons = 0;
  always #50 pclk = ~pclk;
  fsbl_host u_fsbl_host (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wp_n(wp_n), .ce_n(ce_n));
  fsbl_ctrl u_fsbl_ctrl (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wp_n(wp_n), .ce_n(ce_n), .standby(standby));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // flash write: address register, then code
  task automatic cmd(input logic [31:0] a, input logic [15:0] c);
    u_fsbl_host.xfer(1'b1, fsbl_pkg::REG_CMD_ADDR, a, r);
    u_fsbl_host.xfer(1'b1, fsbl_pkg::REG_CMD_DATA, {16'h0000, c}, r);
  endtask
  // lock word sits at block base plus two
  task automatic lockword(input logic [31:0] b, input logic [1:0] e);
    cmd(b + 32'h2, fsbl_pkg::CMD_READ_ID);
    u_fsbl_host.xfer(1'b0, fsbl_pkg::REG_READ, 32'h0, r);
    chk({30'h0, r[1:0]}, {30'h0, e});
  endtask
  // bounded poll on one status bit
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      u_fsbl_host.xfer(1'b0, fsbl_pkg::REG_STATUS, 32'h0, r);
      n++;
    end while (r[b] !== 1'b1 && n < 400);
    if (r[b] !== 1'b1) timeout();
  endtask
  task automatic t_lock();
    lockword(32'h000, 2'b01);
    cmd(32'h100, fsbl_pkg::CMD_LOCK_SETUP);
    cmd(32'h100, fsbl_pkg::CMD_UNLOCK);
    lockword(32'h100, 2'b00);
    cmd(32'h100, fsbl_pkg::CMD_LOCK_SETUP);
    cmd(32'h100, fsbl_pkg::CMD_LOCKDOWN);
    lockword(32'h100, 2'b10);
    u_fsbl_host.wp_n <= 1'b0;
    lockword(32'h100, 2'b11);
  endtask
  task automatic t_blank();
    cmd(32'h200, fsbl_pkg::CMD_BLANK_SETUP);
    cmd(32'h200, fsbl_pkg::CMD_CONFIRM);
    u_fsbl_host.xfer(1'b0, fsbl_pkg::REG_STATUS, 32'h0, r);
    chk({31'h0, r[7]}, 32'h0);
    poll(7);
  endtask
  // erase, suspend, then resume; unlocked first since reset locks all
  task automatic t_susp();
    cmd(32'h300, fsbl_pkg::CMD_LOCK_SETUP);
    cmd(32'h300, fsbl_pkg::CMD_UNLOCK);
    cmd(32'h300, fsbl_pkg::CMD_ERASE_SETUP);
    cmd(32'h300, fsbl_pkg::CMD_CONFIRM);
    cmd(32'h000, fsbl_pkg::CMD_SUSPEND);
    poll(7);
    chk({30'h0, r[6], r[2]}, 32'h2);
    cmd(32'h000, fsbl_pkg::CMD_RESUME);
    u_fsbl_host.xfer(1'b0, fsbl_pkg::REG_STATUS, 32'h0, r);
    chk({30'h0, r[7], r[6]}, 32'h0);
    poll(7);
  endtask
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    conclude();
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_lock();
    t_blank();
    t_susp();
    conclude();
  end
endmodule
bind fsbl_ctrl fsbl_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .ce_n(ce_n), .standby(standby));
